// File: logic/imst_pkg.sv
/*
  Shared constants of the self-test control pair: device register map,
  command codes, field positions, link frame layout, host register map,
  timing figures.
  Assumes a 100 MHz sys_clk in both ends.
*/
`default_nettype none
package imst_pkg;
  // clock and timing
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int SETTLE_MS = 50;
  localparam int SETTLE_CYCLES = (SYS_CLK_HZ / 1000) * SETTLE_MS;
  localparam int LINK_HALF = 8;
  localparam int GYR_TEST_CYCLES = 64;
  localparam int MAG_TEST_CYCLES = 64;

  // device register addresses (7 bit)
  localparam logic [6:0] ADDR_CMD = 7'h7E;
  localparam logic [6:0] ADDR_ACC_CONF = 7'h40;
  localparam logic [6:0] ADDR_ACC_RANGE = 7'h41;
  localparam logic [6:0] ADDR_SELF_TEST = 7'h6D;
  localparam logic [6:0] ADDR_STATUS = 7'h1B;
  localparam logic [6:0] ADDR_MAG_IF0 = 7'h4C;
  localparam logic [6:0] ADDR_MAG_IF1 = 7'h4D;
  localparam logic [6:0] ADDR_MAG_IF2 = 7'h4E;
  localparam logic [6:0] ADDR_MAG_IF3 = 7'h4F;
  localparam logic [6:0] ADDR_MAG_DATA = 7'h04;

  // command codes
  localparam logic [7:0] CMD_ACC_NORMAL = 8'h11;
  localparam logic [7:0] CMD_MAG_IF_NORMAL = 8'h19;

  // reset values
  localparam logic [7:0] ACC_CONF_RST = 8'h28;
  localparam logic [7:0] ACC_RANGE_RST = 8'h03;

  // self-test register fields
  localparam int ST_ACC_EN_LO = 0;
  localparam int ST_ACC_SIGN = 2;
  localparam int ST_ACC_AMP = 3;
  localparam int ST_GYR_START = 4;
  localparam logic [1:0] ACC_EN_ON = 2'h1;
  localparam int STATUS_GYR_OK = 1;
  localparam int MAG_IF_MANUAL = 7;

  // magnetometer indirect registers and fields
  localparam logic [7:0] MAG_REG_XRES = 8'h42;
  localparam logic [7:0] MAG_REG_YRES = 8'h44;
  localparam logic [7:0] MAG_REG_ZRES = 8'h46;
  localparam logic [7:0] MAG_REG_CTRL = 8'h4C;
  localparam int MAG_ST_BIT = 0;
  localparam int MAG_COIL_LO = 6;
  localparam logic [1:0] COIL_OFF = 2'h0;
  localparam logic [1:0] COIL_NEG = 2'h2;
  localparam logic [1:0] COIL_POS = 2'h3;

  // link frame: rw, 7-bit address, 8-bit data, msb first
  localparam int FRAME_BITS = 16;
  localparam int FRAME_RW = 15;
  localparam logic [4:0] FRAME_ADDR_BITS = 5'h08;
  localparam logic [4:0] FRAME_LEN = 5'h10;

  // host wishbone registers (byte addresses)
  localparam logic [3:0] HREG_CTRL = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h4;
  localparam logic [3:0] HREG_MASK = 4'h8;
  localparam logic [3:0] HREG_RDATA = 4'hC;
  localparam int EV_XFER = 0;
  localparam int EV_SETTLE = 1;
  localparam int RD_BUSY = 8;
  localparam int RD_SETTLING = 9;
endpackage
`default_nettype wire

// File: logic/imst_link_if.sv
/*
  Serial link between the host end and the device end.
  Host makes the link clock by division; device samples it.
*/
`timescale 1ns/1ns
`default_nettype none
interface imst_link_if;
  logic sck;
  logic csN;
  logic mosi;
  logic miso;
  modport device (input sck, input csN, input mosi, output miso);
  modport host (output sck, output csN, output mosi, input miso);
endinterface
`default_nettype wire

// File: logic/imst_sync.sv
/*
  Two flip-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a slow level relative to sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module imst_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// File: logic/imst_device.sv
/*
  Device end: link slave, register file and self-test control for the
  accelerometer, gyroscope and magnetometer.
  Assumes the sensor cores run on sys_clk and report through plain levels.
*/
// Operation
// RULE1: accel normal mode via command 0x11
// RULE2: host loads accel config 0x2C, range 0x08
// RULE3: enable field 0b01 starts accel test
// RULE4: sign bit picks negative or positive deflection
// RULE5: host sets amplitude bit high
// RULE6: host waits 50 ms before reading data
// RULE7: host compares both polarities, 2 g minimum
// RULE8: reset after test, else 50 ms interrupt pause
// RULE9: gyro start bit launches gyro test
// RULE10: gyro result in status pass bit
// RULE11: mag interface normal, then setup mode
// RULE12: mag start bit self-clears on completion
// RULE13: per-axis mag results in bit0
// RULE14: coil select decode 00, 01, 10, 11
// RULE15: coil current only while measuring
// RULE16: host advanced coil test sequence
`timescale 1ns/1ns
`default_nettype none
module imst_device
  import imst_pkg::*;
#(
  parameter int GYR_CYCLES = GYR_TEST_CYCLES,
  parameter int MAG_CYCLES = MAG_TEST_CYCLES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  imst_link_if.device link,
  input wire logic gyroDriveOk,
  input wire logic [2:0] magAxisOk,
  input wire logic magSleep,
  input wire logic magMeasActive,
  output logic accNormalMode,
  output logic magIfNormalMode,
  output logic accDeflectPos,
  output logic accDeflectNeg,
  output logic accHighAmp,
  output logic gyroTestActive,
  output logic magTestActive,
  output logic coilCurrentPos,
  output logic coilCurrentNeg
);
  localparam int CW = $clog2(GYR_CYCLES > MAG_CYCLES ? GYR_CYCLES : MAG_CYCLES) + 1;
  localparam logic [CW-1:0] GYR_LAST = CW'(GYR_CYCLES - 1);
  localparam logic [CW-1:0] MAG_LAST = CW'(MAG_CYCLES - 1);

  typedef struct packed {
    logic sckPrev;
    logic [4:0] bitCnt;
    logic [15:0] rxShift;
    logic [7:0] txShift;
    logic miso;
    logic accNormal;
    logic magIfNormal;
    logic [7:0] accConf;
    logic [7:0] accRange;
    logic [1:0] accEn;
    logic accSign;
    logic accAmp;
    logic gyrBusy;
    logic gyrOk;
    logic [CW-1:0] gyrCnt;
    logic magManual;
    logic [7:0] magRdAddr;
    logic [7:0] magWrData;
    logic [7:0] magRdData;
    logic magStart;
    logic [1:0] coilSel;
    logic [2:0] magRes;
    logic [CW-1:0] magCnt;
    logic deflPos;
    logic deflNeg;
    logic coilPos;
    logic coilNeg;
  } imst_dev_s;

  imst_dev_s r;
  imst_dev_s next_r;
  logic sckS;
  logic selS;
  logic mosiS;

  ////////////////////////////////////////////////////////////////////////
  // link pins come from another domain; select enters inverted so a cleared stage reads idle
  imst_sync #(
    .W(3)
  ) linkSync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .d({link.sck, !link.csN, link.mosi}),
    .q({sckS, selS, mosiS})
  );

  ////////////////////////////////////////////////////////////////////////
  // indirect magnetometer register view
  function automatic logic [7:0] magRead(input logic [7:0] a, input imst_dev_s s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      MAG_REG_XRES: v[MAG_ST_BIT] = s.magRes[0]; // see RULE13
      MAG_REG_YRES: v[MAG_ST_BIT] = s.magRes[1]; // see RULE13
      MAG_REG_ZRES: v[MAG_ST_BIT] = s.magRes[2]; // see RULE13
      MAG_REG_CTRL: begin
        v[MAG_COIL_LO +: 2] = s.coilSel;
        v[MAG_ST_BIT] = s.magStart;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // primary register view seen by link reads
  function automatic logic [7:0] regRead(input logic [6:0] a, input imst_dev_s s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_ACC_CONF: v = s.accConf;
      ADDR_ACC_RANGE: v = s.accRange;
      ADDR_SELF_TEST: begin
        v[ST_ACC_EN_LO +: 2] = s.accEn;
        v[ST_ACC_SIGN] = s.accSign;
        v[ST_ACC_AMP] = s.accAmp;
        v[ST_GYR_START] = s.gyrBusy;
      end
      ADDR_STATUS: v[STATUS_GYR_OK] = s.gyrOk; // see RULE10
      ADDR_MAG_IF0: v[MAG_IF_MANUAL] = s.magManual;
      ADDR_MAG_IF1: v = s.magRdAddr;
      ADDR_MAG_IF3: v = s.magWrData;
      ADDR_MAG_DATA: v = s.magRdData;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-state logic: link slave, register writes, test sequencers
  always_comb begin
    logic sckRise;
    logic sckFall;
    logic [15:0] frame;
    logic [6:0] wAddr;
    logic [7:0] wData;
    sckRise = 1'b0;
    sckFall = 1'b0;
    frame = 16'h0000;
    wAddr = 7'h00;
    wData = 8'h00;
    next_r = r;
    next_r.sckPrev = sckS;
    sckRise = sckS && !r.sckPrev && selS;
    sckFall = !sckS && r.sckPrev && selS;

    // frame receive; a deselect aborts any partial frame
    if (!selS) begin
      next_r.bitCnt = 5'h00;
      next_r.miso = 1'b0;
    end else if (sckRise) begin
      frame = {r.rxShift[14:0], mosiS};
      next_r.rxShift = frame;
      next_r.bitCnt = r.bitCnt + 5'h01;
      if (r.bitCnt + 5'h01 == FRAME_LEN && !frame[FRAME_RW]) begin
        wAddr = frame[14:8];
        wData = frame[7:0];
        // register write effects
        case (wAddr)
          ADDR_CMD: begin
            if (wData == CMD_ACC_NORMAL) begin
              next_r.accNormal = 1'b1; // see RULE1
            end
            if (wData == CMD_MAG_IF_NORMAL) begin
              next_r.magIfNormal = 1'b1; // see RULE11
            end
          end
          ADDR_ACC_CONF: next_r.accConf = wData; // see RULE2
          ADDR_ACC_RANGE: next_r.accRange = wData; // see RULE2
          ADDR_SELF_TEST: begin
            next_r.accEn = wData[ST_ACC_EN_LO +: 2]; // see RULE3
            next_r.accSign = wData[ST_ACC_SIGN];
            next_r.accAmp = wData[ST_ACC_AMP]; // see RULE5
            // a start during a running test is ignored
            if (wData[ST_GYR_START] && !r.gyrBusy) begin
              next_r.gyrBusy = 1'b1; // see RULE9
              next_r.gyrOk = 1'b0;
              next_r.gyrCnt = '0;
            end
          end
          ADDR_MAG_IF0: begin
            // setup mode only takes once the interface is in normal mode
            next_r.magManual = wData[MAG_IF_MANUAL] && r.magIfNormal; // see RULE11
          end
          ADDR_MAG_IF1: begin
            next_r.magRdAddr = wData;
            if (r.magManual) begin
              next_r.magRdData = magRead(wData, r);
            end
          end
          ADDR_MAG_IF2: begin
            if (r.magManual && wData == MAG_REG_CTRL) begin
              next_r.coilSel = r.magWrData[MAG_COIL_LO +: 2]; // see RULE14
              if (r.magWrData[MAG_ST_BIT] && magSleep && !r.magStart) begin
                next_r.magStart = 1'b1; // see RULE12
                next_r.magCnt = '0;
              end
            end
          end
          ADDR_MAG_IF3: next_r.magWrData = wData;
          default: next_r.magWrData = r.magWrData;
        endcase
      end
    end else if (sckFall) begin
      // read data leaves msb first after the address byte
      if (r.bitCnt == FRAME_ADDR_BITS && r.rxShift[7]) begin
        next_r.txShift = regRead(r.rxShift[6:0], r);
        next_r.miso = next_r.txShift[7];
      end else if (r.bitCnt > FRAME_ADDR_BITS) begin
        next_r.txShift = {r.txShift[6:0], 1'b0};
        next_r.miso = r.txShift[6];
      end
    end

    // gyro test timer, result latched from the drive monitor
    if (r.gyrBusy) begin
      next_r.gyrCnt = r.gyrCnt + CW'(1);
      if (r.gyrCnt == GYR_LAST) begin
        next_r.gyrBusy = 1'b0;
        next_r.gyrOk = gyroDriveOk; // see RULE10
      end
    end

    // mag normal test; the start bit drops back when done
    if (r.magStart) begin
      next_r.magCnt = r.magCnt + CW'(1);
      if (r.magCnt == MAG_LAST) begin
        next_r.magStart = 1'b0; // see RULE12
        next_r.magRes = magAxisOk; // see RULE13
      end
    end

    // deflection drive, only for enable pattern 01 in accel normal mode
    next_r.deflPos = r.accNormal && r.accEn == ACC_EN_ON && r.accSign; // see RULE3
    next_r.deflNeg = r.accNormal && r.accEn == ACC_EN_ON && !r.accSign; // see RULE4

    // coil current only in the measurement phase; 01 drives nothing
    next_r.coilPos = magMeasActive && r.coilSel == COIL_POS; // see RULE14
    next_r.coilNeg = magMeasActive && r.coilSel == COIL_NEG; // see RULE15
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r <= '0;
      r.accConf <= ACC_CONF_RST;
      r.accRange <= ACC_RANGE_RST;
      r.coilSel <= COIL_OFF; // see RULE14
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  assign link.miso = r.miso;
  assign accNormalMode = r.accNormal;
  assign magIfNormalMode = r.magIfNormal;
  assign accDeflectPos = r.deflPos;
  assign accDeflectNeg = r.deflNeg;
  assign accHighAmp = r.accAmp;
  assign gyroTestActive = r.gyrBusy;
  assign magTestActive = r.magStart;
  assign coilCurrentPos = r.coilPos;
  assign coilCurrentNeg = r.coilNeg;
endmodule
`default_nettype wire

// File: logic/imst_host.sv
/*
  Host end: Wishbone classic slave that sends link frames to the device,
  collects read data, and times the settle waits before results count.
  Assumes software builds frames as rw, address, data.
*/
`timescale 1ns/1ns
`default_nettype none
module imst_host
  import imst_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES,
  parameter int HALF = LINK_HALF
) (
  input wire logic sys_clk,
  input wire logic resetn,
  imst_link_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq
);
  localparam logic [7:0] HALF_LAST = 8'(HALF - 1);
  localparam logic [31:0] SETTLE_LAST = 32'(SETTLE - 1);

  typedef enum logic [1:0] {
    IMST_IDLE = 2'b00,
    IMST_SHIFT = 2'b01,
    IMST_GAP = 2'b11
  } imst_state_e;

  typedef struct packed {
    imst_state_e state;
    logic [7:0] div;
    logic [4:0] bitCnt;
    logic [15:0] tx;
    logic [7:0] rx;
    logic sck;
    logic csN;
    logic mosi;
    logic settling;
    logic [31:0] settleCnt;
    logic [1:0] evStatus;
    logic [1:0] evMask;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } imst_host_s;

  imst_host_s r;
  imst_host_s next_r;
  logic misoS;

  imst_sync #(
    .W(1)
  ) misoSync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .d(link.miso),
    .q(misoS)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus slave, frame shifter, settle timer, interrupt
  always_comb begin
    logic req;
    logic [1:0] ev;
    req = wb_cyc_i && wb_stb_i && !r.ack;
    ev = 2'b00;
    next_r = r;
    next_r.ack = req;

    case (r.state)
      IMST_SHIFT: begin
        next_r.div = r.div + 8'h01;
        if (r.div == HALF_LAST) begin
          next_r.div = 8'h00;
          if (!r.sck) begin
            next_r.sck = 1'b1;
            next_r.rx = {r.rx[6:0], misoS};
            next_r.bitCnt = r.bitCnt + 5'h01;
          end else begin
            next_r.sck = 1'b0;
            next_r.tx = {r.tx[14:0], 1'b0};
            next_r.mosi = r.tx[14];
            if (r.bitCnt == FRAME_LEN) begin
              next_r.state = IMST_GAP;
              next_r.csN = 1'b1;
            end
          end
        end
      end
      IMST_GAP: begin
        // deselect long enough for the device's synchroniser
        next_r.div = r.div + 8'h01;
        if (r.div == HALF_LAST) begin
          next_r.div = 8'h00;
          next_r.state = IMST_IDLE;
          ev[EV_XFER] = 1'b1;
        end
      end
      default: begin
        next_r.state = IMST_IDLE;
      end
    endcase

    // settle wait after a self-test write; see RULE6 and RULE8
    if (r.settling) begin
      next_r.settleCnt = r.settleCnt + 32'h1;
      if (r.settleCnt == SETTLE_LAST) begin
        next_r.settling = 1'b0;
        ev[EV_SETTLE] = 1'b1;
      end
    end

    // register access; a frame write while busy is dropped
    if (req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        HREG_CTRL: begin
          if (r.state == IMST_IDLE) begin
            next_r.state = IMST_SHIFT;
            next_r.tx = wb_dat_i[15:0];
            next_r.mosi = wb_dat_i[FRAME_RW];
            next_r.csN = 1'b0;
            next_r.div = 8'h00;
            next_r.bitCnt = 5'h00;
            if (!wb_dat_i[FRAME_RW] && wb_dat_i[14:8] == ADDR_SELF_TEST) begin
              next_r.settling = 1'b1; // see RULE6
              next_r.settleCnt = 32'h0;
            end
          end
        end
        HREG_MASK: next_r.evMask = wb_dat_i[1:0];
        default: next_r.evMask = r.evMask;
      endcase
    end
    next_r.dat = 32'h0;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        HREG_STATUS: next_r.dat[1:0] = r.evStatus;
        HREG_MASK: next_r.dat[1:0] = r.evMask;
        HREG_RDATA: begin
          next_r.dat[7:0] = r.rx;
          next_r.dat[RD_BUSY] = r.state != IMST_IDLE;
          next_r.dat[RD_SETTLING] = r.settling; // see RULE8
        end
        default: next_r.dat = 32'h0;
      endcase
    end

    // read clears status, a same-cycle event still lands
    if (req && !wb_we_i && wb_adr_i == HREG_STATUS) begin
      next_r.evStatus = ev;
    end else begin
      next_r.evStatus = r.evStatus | ev;
    end
    next_r.irq = |(next_r.evStatus & next_r.evMask);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r <= '0;
      r.state <= IMST_IDLE;
      r.csN <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.sck = r.sck;
  assign link.csN = r.csN;
  assign link.mosi = r.mosi;
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign irq = r.irq;
endmodule
`default_nettype wire

// File: test/imst_check_sva.sv
/*
  Link wire and sensor output checks for the host and device pair.
  Assumes the host runs its link at the default half period of 8 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module imst_check_sva (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  input wire logic accNormalMode,
  input wire logic accDeflectPos,
  input wire logic accDeflectNeg,
  input wire logic coilCurrentPos,
  input wire logic coilCurrentNeg,
  input wire logic magMeasActive,
  input wire logic gyroTestActive
);
  localparam int GYR_MAX = 40;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  // link phases: a device slower than 8 cycles a phase would miss bits
  sequence sckHigh8; sck [*8] ##1 !sck; endsequence
  sequence sckLow8; !sck [*8]; endsequence
  a_sck_high_phase: assert property ($rose(sck) |-> sckHigh8)
    else $error("sck high phase not 8 cycles");
  a_sck_low_phase: assert property ($fell(sck) |-> sckLow8)
    else $error("sck low phase under 8 cycles");
  a_cs_gap: assert property ($rose(csN) |-> csN [*8])
    else $error("select gap under 8 cycles");
  a_sck_idle: assert property (csN |-> !sck)
    else $error("sck not idle low outside frame");
  a_mosi_stable: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("mosi moved while sck high");
  ////////////////////////////////////////
  // sensor drive outputs
  a_deflect_excl: assert property (!(accDeflectPos && accDeflectNeg))
    else $error("both deflect directions on");
  a_deflect_mode: assert property (accDeflectPos || accDeflectNeg |-> accNormalMode)
    else $error("deflect outside accel normal mode");
  a_coil_excl: assert property (!(coilCurrentPos && coilCurrentNeg))
    else $error("both coil currents on");
  a_coil_meas: assert property (
    coilCurrentPos || coilCurrentNeg |-> $past(magMeasActive))
    else $error("coil current outside measurement");
  a_gyro_ends: assert property (
    $rose(gyroTestActive) |-> ##[1:GYR_MAX] !gyroTestActive)
    else $error("gyro test does not end");
endmodule
`default_nettype wire

// File: test/inertial_mag_self_test_control_bench.sv
/*
  Bench for the host and device ends joined by the link interface.
  Assumes Wishbone answers in one cycle and frames report busy in RDATA.
*/
`timescale 1ns/1ns
`default_nettype none
module inertial_mag_self_test_control_bench;
  import imst_pkg::*;
  logic sys_clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0;
  logic gyroDriveOk = 0, magSleep = 0, magMeas = 0;
  logic [3:0] adr = '0;
  logic [31:0] dw = '0, dr;
  logic [2:0] magAxisOk = '0;
  logic ack, irq, accN, magN, dPos, dNeg, amp, gAct, mAct, cPos, cNeg;
  int fail_count = 0, checked = 0, cycles = 0, seed = 40998;
  logic [7:0] model [int]; // expected device register contents
  imst_link_if lnk();
  ////////////////////////////////////////
  // 100 MHz clock and run limit
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      stop_test();
    end
  end
  imst_host #(.SETTLE(100)) i_imst_host (.sys_clk(sys_clk), .resetn(resetn), .link(lnk),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .irq(irq));
  imst_device #(.GYR_CYCLES(8), .MAG_CYCLES(200)) i_imst_device (.sys_clk(sys_clk),
    .resetn(resetn), .link(lnk), .gyroDriveOk(gyroDriveOk), .magAxisOk(magAxisOk),
    .magSleep(magSleep), .magMeasActive(magMeas), .accNormalMode(accN),
    .magIfNormalMode(magN), .accDeflectPos(dPos), .accDeflectNeg(dNeg), .accHighAmp(amp),
    .gyroTestActive(gAct), .magTestActive(mAct), .coilCurrentPos(cPos), .coilCurrentNeg(cNeg));
  imst_check_sva i_imst_check_sva (.sys_clk(sys_clk), .resetn(resetn), .sck(lnk.sck),
    .csN(lnk.csN), .mosi(lnk.mosi), .accNormalMode(accN), .accDeflectPos(dPos),
    .accDeflectNeg(dNeg), .coilCurrentPos(cPos), .coilCurrentNeg(cNeg),
    .magMeasActive(magMeas), .gyroTestActive(gAct));
  ////////////////////////////////////////
  // compare and report
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one classic cycle; request held until ack is seen at an edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge sys_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dw <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = dr;
    cyc <= 0;
    stb <= 0;
  endtask
  // one link frame; busy stays set through the select gap, then 10 more cycles pass
  task automatic frame(input logic rw, input logic [6:0] a, input logic [7:0] d,
                       output logic [7:0] q);
    logic [31:0] r;
    wb(1, HREG_CTRL, {16'h0, rw, a, d}, r);
    r = 32'h100;
    while (r[RD_BUSY] !== 1'b0) wb(0, HREG_RDATA, 32'h0, r);
    q = r[7:0];
    repeat (10) @(posedge sys_clk);
  endtask
  task automatic dwr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    frame(0, a, d, q);
    model[a] = d;
  endtask
  task automatic drd(input string name, input logic [6:0] a);
    logic [7:0] q;
    frame(1, a, 8'h00, q);
    check(name, q, model[a]);
  endtask
  // indirect magnetometer access through the interface registers
  task automatic mwr(input logic [7:0] ma, input logic [7:0] d);
    dwr(ADDR_MAG_IF3, d);
    dwr(ADDR_MAG_IF2, ma);
  endtask
  task automatic mrd(input logic [7:0] ma, output logic [7:0] q);
    dwr(ADDR_MAG_IF1, ma);
    frame(1, ADDR_MAG_DATA, 8'h00, q);
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] q;
    logic [31:0] r;
    int e;
    model[ADDR_ACC_CONF] = ACC_CONF_RST;
    model[ADDR_ACC_RANGE] = ACC_RANGE_RST;
    repeat (16) @(posedge sys_clk);
    resetn <= 1;
    drd("accConfReset", ADDR_ACC_CONF);
    drd("accRangeReset", ADDR_ACC_RANGE);
    wb(0, 4'h2, 32'h0, r);
    check("unmapped", r, 32'h0);
    dwr(ADDR_CMD, CMD_ACC_NORMAL);
    check("accNormal", accN, 1);
    dwr(ADDR_ACC_CONF, 8'h2C);
    dwr(ADDR_ACC_RANGE, 8'h08);
    drd("accConf", ADDR_ACC_CONF);
    drd("accRange", ADDR_ACC_RANGE);
    // every enable code with both signs, amplitude high
    for (e = 0; e < 8; e++) begin
      dwr(ADDR_SELF_TEST, {4'h0, 1'b1, e[2], e[1:0]});
      check("deflectPos", dPos, e[1:0] == 2'h1 && e[2]);
      check("deflectNeg", dNeg, e[1:0] == 2'h1 && !e[2]);
      check("accHighAmp", amp, 1);
    end
    // settle event: masked first, then raised, then cleared by reading
    wb(1, HREG_MASK, 32'h0, r);
    wb(0, HREG_STATUS, 32'h0, r);
    dwr(ADDR_SELF_TEST, 8'h09);
    repeat (150) @(posedge sys_clk);
    check("irqMasked", irq, 0);
    wb(1, HREG_MASK, 32'h2, r);
    repeat (3) @(posedge sys_clk);
    check("irqSettle", irq, 1);
    wb(0, HREG_STATUS, 32'h0, r);
    check("settleBit", r[EV_SETTLE], 1);
    repeat (3) @(posedge sys_clk);
    check("irqCleared", irq, 0);
    // reset after the accel test rather than the interrupt pause
    resetn <= 0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1;
    model[ADDR_ACC_CONF] = ACC_CONF_RST;
    model[ADDR_ACC_RANGE] = ACC_RANGE_RST;
    check("accNormalReset", accN, 0);
    check("irqReset", irq, 0);
    drd("accConfAgain", ADDR_ACC_CONF);
    // gyro test with a failing and a passing drive
    for (e = 0; e < 2; e++) begin
      gyroDriveOk <= e[0];
      dwr(ADDR_SELF_TEST, 8'h10);
      repeat (20) @(posedge sys_clk);
      frame(1, ADDR_STATUS, 8'h00, q);
      check("gyroOk", q[STATUS_GYR_OK], e[0]);
    end
    // normal magnetometer test with random axis outcomes
    magAxisOk <= 3'($random(seed));
    magSleep <= 1;
    dwr(ADDR_CMD, CMD_MAG_IF_NORMAL);
    check("magIfNormal", magN, 1);
    dwr(ADDR_MAG_IF0, 8'h80);
    mwr(MAG_REG_CTRL, 8'h01);
    check("magActive", mAct, 1);
    mrd(MAG_REG_CTRL, q);
    check("magStartClear", q[MAG_ST_BIT], 0);
    for (e = 0; e < 3; e++) begin
      mrd(8'(MAG_REG_XRES + 2 * e), q);
      check("magAxis", q[0], magAxisOk[e]);
    end
    // coil select codes, measurement phase on then off
    for (e = 0; e < 4; e++) begin
      mwr(MAG_REG_CTRL, 8'(e << MAG_COIL_LO));
      magMeas <= 1;
      repeat (3) @(posedge sys_clk);
      check("coilPos", cPos, e == 3);
      check("coilNeg", cNeg, e == 2);
      magMeas <= 0;
      repeat (3) @(posedge sys_clk);
      check("coilIdle", cPos | cNeg, 0);
    end
    // the coil select stays set until cleared by hand
    mwr(MAG_REG_CTRL, 8'h00);
    mrd(MAG_REG_CTRL, q);
    check("coilCleared", q, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
